// ---- contact_output_pkg.sv ----
package contact_output_pkg;

  typedef enum logic [3:0] {
    SRC_OFF, SRC_RUN, SRC_REMOTE, SRC_READY, SRC_STOP_ALM, SRC_CONT_ALM, SRC_ANY_ALM,
    SRC_SEL_ALM, SRC_START_TMR, SRC_STOP_TMR, SRC_PWR_RST, SRC_FREEZE, SRC_INPUT_ONE_PASSTHROUGH,
    SRC_INPUT_TWO_PASSTHROUGH, SRC_WARM, SRC_SNOW
  } source_e;

  typedef struct packed {
    source_e src;
    logic    normClosed;
  } outCfg_s;

  // Status vector supplied by the rest of the product
  typedef struct packed {
    logic       running;
    logic       remoteMode;
    logic       tempReady;
    logic       stoppingFault;
    logic       continuingFault;
    logic       otherFault;
    logic [7:0] alarmVec;
    logic       startTimerArmed;
    logic       stopTimerArmed;
    logic       powerRestartEn;
    logic       antiFreezeEn;
    logic       warmUpEn;
    logic       antiSnowEn;
  } productStatus_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apbReq_s;

  localparam int NUM_OUT = 3;
  localparam int ALARM_W = 8;

  localparam logic [7:0] OUT1_CFG_ADDR  = 8'h00;
  localparam logic [7:0] OUT2_CFG_ADDR  = 8'h04;
  localparam logic [7:0] OUT3_CFG_ADDR  = 8'h08;
  localparam logic [7:0] ALARM_SEL_ADDR = 8'h0c;
  localparam logic [7:0] CTRL_ADDR      = 8'h10;
  localparam logic [7:0] STATE_ADDR     = 8'h14;

  localparam int CFG_SRC_LSB   = 0;
  localparam int CFG_NC_BIT    = 4;
  localparam int CTRL_RMTALT   = 0;
  localparam int STATE_CONT_LSB = 0;
  localparam int STATE_IN1_BIT = 4;
  localparam int STATE_IN2_BIT = 5;
  localparam int STATE_RMT_BIT = 6;
  localparam int STATE_WC_BIT  = 7;

  localparam outCfg_s OUT1_CFG_RST = '{src: SRC_RUN,     normClosed: 1'b0};
  localparam outCfg_s OUT2_CFG_RST = '{src: SRC_REMOTE,  normClosed: 1'b0};
  localparam outCfg_s OUT3_CFG_RST = '{src: SRC_ANY_ALM, normClosed: 1'b1};
  localparam logic [7:0] ALARM_SEL_RST = 8'h00;
  localparam logic       RMTALT_RST    = 1'b1;

endpackage

// ---- contact_output_selector.sv ----
module contact_output_selector (
  input  wire logic                               mclk,
  input  wire logic                               rst,
  input  wire contact_output_pkg::apbReq_s        apbReq,
  output logic                                    pready,
  output logic [31:0]                             prdata,
  output logic                                    pslverr,
  input  wire contact_output_pkg::productStatus_s status,
  input  wire logic                               contactIn1,
  input  wire logic                               contactIn2,
  input  wire logic                               waterCooledStrap,
  output logic [2:0]                              contactClosed
);

  // **********************************************************************
  // State
  // **********************************************************************
  typedef struct packed {
    contact_output_pkg::outCfg_s [2:0] cfg;
    logic [7:0]                        alarmSel;
    logic                              remoteAlt;
    logic                              waterCooled;
    logic                              strapTaken;
    logic [2:0]                        in1Sync;
    logic [2:0]                        in2Sync;
    logic                              in1;
    logic                              in2;
    logic [2:0]                        contacts;
    logic                              ready;
    logic [31:0]                       rdata;
    logic                              slverr;
  } state_s;

  localparam state_s STATE_RST = '{
    cfg:         {contact_output_pkg::OUT3_CFG_RST,
                  contact_output_pkg::OUT2_CFG_RST,
                  contact_output_pkg::OUT1_CFG_RST},
    alarmSel:    contact_output_pkg::ALARM_SEL_RST,
    remoteAlt:   contact_output_pkg::RMTALT_RST,
    waterCooled: 1'b0,
    strapTaken:  1'b0,
    in1Sync:     3'h0,
    in2Sync:     3'h0,
    in1:         1'b0,
    in2:         1'b0,
    contacts:    3'h0,
    ready:       1'b0,
    rdata:       32'h0,
    slverr:      1'b0
  };

  state_s cur_ff;
  state_s nxt_cur;

  // **********************************************************************
  // Status source selection
  // **********************************************************************
  function automatic logic pickSource(
    input contact_output_pkg::source_e        src,
    input contact_output_pkg::productStatus_s st,
    input logic                               remote_mode_status,
    input logic [7:0]                         sel,
    input logic                               snowOk,
    input logic                               in1,
    input logic                               in2
  );
    logic v;
    v = 1'b0;
    unique case (src)
      contact_output_pkg::SRC_OFF:       v = 1'b0;
      contact_output_pkg::SRC_RUN:       v = st.running;
      contact_output_pkg::SRC_REMOTE:    v = remote_mode_status;
      contact_output_pkg::SRC_READY:     v = st.tempReady;
      contact_output_pkg::SRC_STOP_ALM:  v = st.stoppingFault;
      contact_output_pkg::SRC_CONT_ALM:  v = st.continuingFault;
      contact_output_pkg::SRC_ANY_ALM:
        v = st.stoppingFault | st.continuingFault | st.otherFault;
      contact_output_pkg::SRC_SEL_ALM:   v = |(st.alarmVec & sel);
      contact_output_pkg::SRC_START_TMR: v = st.startTimerArmed;
      contact_output_pkg::SRC_STOP_TMR:  v = st.stopTimerArmed;
      contact_output_pkg::SRC_PWR_RST:   v = st.powerRestartEn;
      contact_output_pkg::SRC_FREEZE:    v = st.antiFreezeEn;
      // Debounced level only; a momentary input gives no stable meaning here
      contact_output_pkg::SRC_INPUT_ONE_PASSTHROUGH:      v = in1;
      contact_output_pkg::SRC_INPUT_TWO_PASSTHROUGH:      v = in2;
      contact_output_pkg::SRC_WARM:      v = st.warmUpEn;
      contact_output_pkg::SRC_SNOW:      v = st.antiSnowEn & snowOk;
    endcase
    return v;
  endfunction

  // **********************************************************************
  // Next state
  // **********************************************************************
  always_comb
  begin
    logic                   remoteNow;
    logic                   access;
    logic                   takeWrite;
    logic [31:0]            rd;
    logic                   err;
    logic [3:0]             wSrc;
    contact_output_pkg::outCfg_s wCfg;
    remoteNow = 1'b0;
    access    = 1'b0;
    takeWrite = 1'b0;
    rd        = 32'h0;
    err       = 1'b0;
    wSrc      = 4'h0;
    wCfg      = contact_output_pkg::OUT1_CFG_RST;
    nxt_cur   = cur_ff;

    // Strap caught once, on the first clock after reset release
    if (!cur_ff.strapTaken)
    begin
      nxt_cur.waterCooled = waterCooledStrap;
      nxt_cur.strapTaken  = 1'b1;
    end

    // Three-stage input capture; a level counts once stages two and three agree
    nxt_cur.in1Sync = {cur_ff.in1Sync[1:0], contactIn1};
    nxt_cur.in2Sync = {cur_ff.in2Sync[1:0], contactIn2};
    if (cur_ff.in1Sync[1] == cur_ff.in1Sync[2])
    begin
      nxt_cur.in1 = cur_ff.in1Sync[2];
    end
    if (cur_ff.in2Sync[1] == cur_ff.in2Sync[2])
    begin
      nxt_cur.in2 = cur_ff.in2Sync[2];
    end

    // Alternate remote input overrides the product's own remote mode flag
    remoteNow = cur_ff.remoteAlt ? cur_ff.in2 : status.remoteMode;

    // Contacts use the registered config, so defaults apply first after reset
    for (int i = 0; i < contact_output_pkg::NUM_OUT; i++)
    begin
      nxt_cur.contacts[i] = pickSource(cur_ff.cfg[i].src, status, remoteNow,
                                       cur_ff.alarmSel, !cur_ff.waterCooled,
                                       cur_ff.in1, cur_ff.in2)
                            ^ cur_ff.cfg[i].normClosed;
    end

    // APB slave: answer one cycle into the access phase, then drop ready
    access    = apbReq.psel & apbReq.penable;
    takeWrite = access & cur_ff.ready & apbReq.pwrite & !cur_ff.slverr;
    nxt_cur.ready = access & !cur_ff.ready;

    unique case (apbReq.paddr)
      contact_output_pkg::OUT1_CFG_ADDR,
      contact_output_pkg::OUT2_CFG_ADDR,
      contact_output_pkg::OUT3_CFG_ADDR:
      begin
        wCfg = cur_ff.cfg[apbReq.paddr[3:2]];
        rd[contact_output_pkg::CFG_SRC_LSB +: 4] = wCfg.src;
        rd[contact_output_pkg::CFG_NC_BIT]       = wCfg.normClosed;
      end
      contact_output_pkg::ALARM_SEL_ADDR:
        rd[contact_output_pkg::ALARM_W-1:0] = cur_ff.alarmSel;
      contact_output_pkg::CTRL_ADDR:
        rd[contact_output_pkg::CTRL_RMTALT] = cur_ff.remoteAlt;
      contact_output_pkg::STATE_ADDR:
      begin
        rd[contact_output_pkg::STATE_CONT_LSB +: 3] = cur_ff.contacts;
        rd[contact_output_pkg::STATE_IN1_BIT]       = cur_ff.in1;
        rd[contact_output_pkg::STATE_IN2_BIT]       = cur_ff.in2;
        rd[contact_output_pkg::STATE_RMT_BIT]       = remoteNow;
        rd[contact_output_pkg::STATE_WC_BIT]        = cur_ff.waterCooled;
      end
      default:
        err = 1'b1;
    endcase

    // Answer stands for exactly the ready cycle, so the bus reads idle right after it
    if (access & !cur_ff.ready)
    begin
      nxt_cur.rdata  = apbReq.pwrite ? 32'h0 : rd;
      nxt_cur.slverr = err;
    end
    else
    begin
      nxt_cur.rdata  = 32'h0;
      nxt_cur.slverr = 1'b0;
    end

    // Write lands on the edge where the master sees pready high
    if (takeWrite)
    begin
      wSrc = apbReq.pwdata[contact_output_pkg::CFG_SRC_LSB +: 4];
      unique case (apbReq.paddr)
        contact_output_pkg::OUT1_CFG_ADDR,
        contact_output_pkg::OUT2_CFG_ADDR,
        contact_output_pkg::OUT3_CFG_ADDR:
        begin
          nxt_cur.cfg[apbReq.paddr[3:2]].src        = contact_output_pkg::source_e'(wSrc);
          nxt_cur.cfg[apbReq.paddr[3:2]].normClosed =
            apbReq.pwdata[contact_output_pkg::CFG_NC_BIT];
        end
        contact_output_pkg::ALARM_SEL_ADDR:
          nxt_cur.alarmSel = apbReq.pwdata[contact_output_pkg::ALARM_W-1:0];
        contact_output_pkg::CTRL_ADDR:
          nxt_cur.remoteAlt = apbReq.pwdata[contact_output_pkg::CTRL_RMTALT];
        default:
          nxt_cur.remoteAlt = cur_ff.remoteAlt;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cur_ff <= STATE_RST;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign pready        = cur_ff.ready;
  assign prdata        = cur_ff.rdata;
  assign pslverr       = cur_ff.slverr;
  assign contactClosed = cur_ff.contacts;

endmodule

// ---- contact_output_selector_props.sv ----
module contact_output_selector_props (
  input wire logic                               mclk,
  input wire logic                               rst,
  input wire contact_output_pkg::apbReq_s        apbReq,
  input wire logic                               pready,
  input wire logic [31:0]                        prdata,
  input wire logic                               pslverr,
  input wire contact_output_pkg::productStatus_s status,
  input wire logic                               contactIn1,
  input wire logic                               contactIn2,
  input wire logic                               waterCooledStrap,
  input wire logic [2:0]                         contactClosed
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic cfgWr;
  assign cfgWr = pready && apbReq.psel && apbReq.pwrite && apbReq.paddr == 8'h00;
  property p_rdyOnce;
    pready |=> !pready;
  endproperty
  a_rdyOnce: assert property (p_rdyOnce) else $error("ready held too long");
  property p_rdyCause;
    pready |-> $past(apbReq.psel) && $past(apbReq.penable);
  endproperty
  a_rdyCause: assert property (p_rdyCause) else $error("ready without access");
  property p_rdyBound;
    apbReq.psel && apbReq.penable && !pready |=> pready;
  endproperty
  a_rdyBound: assert property (p_rdyBound) else $error("access not answered");
  property p_errMap;
    pready && apbReq.paddr > 8'h14 |-> pslverr && prdata == 32'h0;
  endproperty
  a_errMap: assert property (p_errMap) else $error("unmapped access not refused");
  property p_idle;
    !pready |-> !pslverr && prdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("bus outputs not idle");
  property p_rstOpen;
    $fell(rst) |-> contactClosed == 3'b000;
  endproperty
  a_rstOpen: assert property (p_rstOpen) else $error("contacts not open after reset");
  property p_dflt;
    $fell(rst) |=> contactClosed[0] == $past(status.running) && contactClosed[2] ==
      !($past(status.stoppingFault) || $past(status.continuingFault) || $past(status.otherFault));
  endproperty
  a_dflt: assert property (p_dflt) else $error("default outputs wrong");
  property p_offOpen;
    cfgWr && apbReq.pwdata[4:0] == 5'h00 |-> ##2 !contactClosed[0];
  endproperty
  a_offOpen: assert property (p_offOpen) else $error("unused open contact closed");
  property p_offClosed;
    cfgWr && apbReq.pwdata[4:0] == 5'h10 |-> ##2 contactClosed[0];
  endproperty
  a_offClosed: assert property (p_offClosed) else $error("unused closed contact open");
endmodule

bind contact_output_selector contact_output_selector_props chk_u (.*);

// ---- contact_partner.sv ----
module contact_partner (
  input  wire logic       mclk,
  input  wire logic       in1Cmd,
  input  wire logic       in2Cmd,
  input  wire logic [2:0] contactClosed,
  output logic            contactIn1,
  output logic            contactIn2,
  output logic [2:0]      seenClosed
);
  timeunit 1ns;
  timeprecision 1ns;
  // Switches are held as steady levels, never pulsed, so pass-through stays valid
  always_ff @(posedge mclk)
  begin
    contactIn1 <= in1Cmd;
    contactIn2 <= in2Cmd;
    seenClosed <= contactClosed;
  end
endmodule

// ---- tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, strap = 0, in1 = 0, in2 = 0, pready, pslverr, c1, c2;
  logic [31:0] prdata, r;
  logic [2:0] cc;
  logic e;
  contact_output_pkg::apbReq_s req = '0;
  contact_output_pkg::productStatus_s st = '0;
  int failCount = 0, compares = 0;
  logic [31:0] rv [5] = '{32'h1, 32'h2, 32'h16, 32'h0, 32'h1};
  always #50 mclk = ~mclk;
  contact_output_selector dut_u (.mclk(mclk), .rst(rst), .apbReq(req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .status(st), .contactIn1(c1), .contactIn2(c2),
    .waterCooledStrap(strap), .contactClosed(cc));
  contact_partner peer_u (.mclk(mclk), .in1Cmd(in1), .in2Cmd(in2), .contactClosed(cc),
    .contactIn1(c1), .contactIn2(c2), .seenClosed());
  task conclude;
    $display("tests %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failCount++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task settle;
    repeat (8) @(posedge mclk);
  endtask
  task doReset;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task drive(input int s, input logic on);
    contact_output_pkg::productStatus_s v;
    v = '0;
    if (on)
      case (s)
        1: v.running = 1'b1;
        2: v.remoteMode = 1'b1;
        3: v.tempReady = 1'b1;
        4: v.stoppingFault = 1'b1;
        5: v.continuingFault = 1'b1;
        6: v.otherFault = 1'b1;
        7: v.alarmVec = 8'h04;
        8: v.startTimerArmed = 1'b1;
        9: v.stopTimerArmed = 1'b1;
        10: v.powerRestartEn = 1'b1;
        11: v.antiFreezeEn = 1'b1;
        14: v.warmUpEn = 1'b1;
        15: v.antiSnowEn = 1'b1;
        default: ;
      endcase
    st <= v;
    in1 <= on && s == 12;
    in2 <= on && s == 13;
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk);
    failCount++;
    conclude;
  end
  initial
  begin
    doReset;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("config reset", rv[i], r);
    end
    settle;
    chk("default contacts", 32'h4, {29'h0, cc});
    drive(1, 1'b1);
    settle;
    chk("running contacts", 32'h5, {29'h0, cc});
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    $display("reset and default test done");
    apb(1'b1, 8'h0c, 32'h4);
    apb(1'b1, 8'h10, 32'h0);
    for (int s = 0; s < 16; s++)
      for (int nc = 0; nc < 2; nc++)
      begin
        apb(1'b1, 8'(4 * (s % 3)), {27'h0, nc[0], s[3:0]});
        drive(s, 1'b0);
        settle;
        chk("idle source", {31'h0, nc[0]}, {31'h0, cc[s % 3]});
        drive(s, 1'b1);
        settle;
        chk("active source", {31'h0, nc[0] ^ (s != 0)}, {31'h0, cc[s % 3]});
      end
    $display("source table test done");
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b1, 8'h04, 32'h2);
    drive(13, 1'b1);
    settle;
    chk("alternate remote", 32'h1, {31'h0, cc[1]});
    strap <= 1'b1;
    doReset;
    apb(1'b1, 8'h00, 32'hf);
    drive(15, 1'b1);
    settle;
    chk("snow masked", 32'h0, {31'h0, cc[0]});
    $display("remote and variant test done");
    conclude;
  end
endmodule
